/* File: core/dtg_regs.svh */
// Register map, field positions, reset values and timing counts
`ifndef DTG_REGS_SVH
`define DTG_REGS_SVH

`define DTG_CLK_HZ      250000000
`define DTG_CLK_MHZ     250
`define DTG_ADDR_DATA   8'h00
`define DTG_ADDR_CTRL_A 8'h04
`define DTG_ADDR_CTRL_B 8'h08
`define DTG_ADDR_STATUS 8'h0C
`define DTG_CA_TONE     0
`define DTG_CA_PROG     1
`define DTG_CA_IRQ      2
`define DTG_CB_BURST    0
`define DTG_ST_IRQ      0
`define DTG_ST_TXRDY    1
`define DTG_ST_RXNEW    2
`define DTG_ST_DSTD     3
`define DTG_CTRL_RST    4'h0
`define DTG_SETTLE_NS   40
`define DTG_SETTLE_CYC  ((`DTG_SETTLE_NS * `DTG_CLK_MHZ + 999) / 1000)
`define DTG_GUARD_MS    40
`define DTG_GUARD_CYC   (`DTG_GUARD_MS * `DTG_CLK_MHZ * 1000)
`define DTG_BURST_MS    51
`define DTG_BURST_CYC   (`DTG_BURST_MS * `DTG_CLK_MHZ * 1000)
`define DTG_SEGS        32
`define DTG_SINE_MID    8'h80
`define DTG_F_ROW0      697
`define DTG_F_ROW1      770
`define DTG_F_ROW2      852
`define DTG_F_ROW3      941
`define DTG_F_COL0      1209
`define DTG_F_COL1      1336
`define DTG_F_COL2      1477
`define DTG_F_COL3      1633
`define DTG_SEG_LEN(f)  (`DTG_CLK_HZ / ((f) * `DTG_SEGS))

`endif

/* File: core/dtg_pkg.sv */
// Types shared by the tone steering and generator core
package dtg_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_QUAL, ST_SETTLE, ST_VALID, ST_ABSENT
  } dtg_steer_t;
  typedef enum logic [1:0] {
    PH_IDLE, PH_BURST, PH_PAUSE
  } dtg_phase_t;
  typedef struct packed {
    logic dstd;
    logic rx_new;
    logic tx_ready;
    logic irq;
  } dtg_status_t;
endpackage

/* File: core/dtg_core.sv */
// Tone steering, receive latch, tone generator and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "dtg_regs.svh"
module dtg_core #(
  parameter int unsigned GTP_CYC   = `DTG_GUARD_CYC,
  parameter int unsigned GTA_CYC   = `DTG_GUARD_CYC,
  parameter int unsigned BURST_CYC = `DTG_BURST_CYC
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // APB slave
  input  wire logic       i_psel,
  input  wire logic       i_penable,
  input  wire logic       i_pwrite,
  input  wire logic [7:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]     o_prdata,
  output logic            o_pready,
  output logic            o_pslverr,
  // Detector side
  input  wire logic       i_early_tone_detect,
  input  wire logic [3:0] i_decoded_digit,
  input  wire logic       i_progress_wave,
  output logic            o_guard_time_drive,
  // Open-drain interrupt or progress pin
  input  wire logic       i_irq_or_progress_pin_i,
  output logic            o_irq_or_progress_pin_o,
  output logic            o_irq_or_progress_pin_oe,
  // Tone samples to the converters
  output logic [7:0]      o_row_sample,
  output logic [7:0]      o_col_sample
);
  localparam int unsigned SETTLE_CYC = `DTG_SETTLE_CYC;

  // Three-stage input synchronisers, change taken when stages 2 and 3 agree
  logic [5:0] sync1, sync2, sync3, filt;
  logic [5:0] raw_in;
  logic [5:0] next_filt;
  assign raw_in = {i_progress_wave, i_early_tone_detect, i_decoded_digit};
  always_comb begin
    next_filt = filt;
    for (int b = 0; b < 6; b++) begin
      if (sync2[b] == sync3[b]) begin
        next_filt[b] = sync3[b];
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 6'h00;
      filt  <= 6'h00;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= next_filt;
    end
  end
  logic       early_tone_detect;
  logic       prog_wave;
  logic [3:0] digit_in;
  assign digit_in  = filt[3:0];
  assign early_tone_detect       = filt[4];
  assign prog_wave = filt[5];

  // Control registers
  logic [3:0] ctrl_a, ctrl_b;
  logic       tone_en, prog_mode, irq_en, burst_en;
  assign tone_en   = ctrl_a[`DTG_CA_TONE];
  assign prog_mode = ctrl_a[`DTG_CA_PROG];
  assign irq_en    = ctrl_a[`DTG_CA_IRQ];
  assign burst_en  = ctrl_b[`DTG_CB_BURST];

  logic wr_acc, rd_acc;
  assign o_pready = 1'b1;
  assign wr_acc   = i_psel & i_penable & i_pwrite;
  assign rd_acc   = i_psel & i_penable & ~i_pwrite;
  logic wr_data, rd_status;
  assign wr_data   = wr_acc && i_paddr == `DTG_ADDR_DATA;
  assign rd_status = rd_acc && i_paddr == `DTG_ADDR_STATUS;

  // Receive steering state machine
  dtg_pkg::dtg_steer_t state, next_state;
  logic [31:0] scnt, next_scnt;
  logic [3:0]  pend, next_pend;
  logic [3:0]  rx_data, next_rx_data;
  logic        dstd, next_dstd;
  logic        guard, next_guard;
  logic        rx_set;
  always_comb begin
    next_state   = state;
    next_scnt    = scnt;
    next_pend    = pend;
    next_rx_data = rx_data;
    next_dstd    = dstd;
    rx_set       = 1'b0;
    case (state)
      dtg_pkg::ST_IDLE: begin
        if (early_tone_detect) begin
          next_state = dtg_pkg::ST_QUAL;
          next_scnt  = 32'h0;
        end
      end
      dtg_pkg::ST_QUAL: begin
        if (!early_tone_detect) begin
          next_state = dtg_pkg::ST_IDLE;
        end else if (scnt >= GTP_CYC - 1) begin
          next_state = dtg_pkg::ST_SETTLE;
          next_pend  = digit_in;
          next_scnt  = 32'h0;
        end else begin
          next_scnt = scnt + 32'h1;
        end
      end
      dtg_pkg::ST_SETTLE: begin
        if (scnt >= SETTLE_CYC - 1) begin
          next_state   = dtg_pkg::ST_VALID;
          next_dstd    = 1'b1;
          next_rx_data = pend;
          rx_set       = 1'b1;
        end else begin
          next_scnt = scnt + 32'h1;
        end
      end
      dtg_pkg::ST_VALID: begin
        if (!early_tone_detect) begin
          next_state = dtg_pkg::ST_ABSENT;
          next_scnt  = 32'h0;
        end
      end
      dtg_pkg::ST_ABSENT: begin
        if (early_tone_detect) begin
          next_state = dtg_pkg::ST_VALID;
        end else if (scnt >= GTA_CYC - 1) begin
          next_state = dtg_pkg::ST_IDLE;
          next_dstd  = 1'b0;
        end else begin
          next_scnt = scnt + 32'h1;
        end
      end
      default: begin
        next_state = dtg_pkg::ST_IDLE;
      end
    endcase
    if (prog_mode) begin
      next_state   = dtg_pkg::ST_IDLE;
      next_dstd    = 1'b0;
      next_rx_data = rx_data;
      rx_set       = 1'b0;
    end
    next_guard = early_tone_detect && (next_state == dtg_pkg::ST_SETTLE ||
                         next_state == dtg_pkg::ST_VALID);
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state   <= dtg_pkg::ST_IDLE;
      scnt    <= 32'h0;
      pend    <= 4'h0;
      rx_data <= 4'h0;
      dstd    <= 1'b0;
      guard   <= 1'b0;
    end else begin
      state   <= next_state;
      scnt    <= next_scnt;
      pend    <= next_pend;
      rx_data <= next_rx_data;
      dstd    <= next_dstd;
      guard   <= next_guard;
    end
  end
  assign o_guard_time_drive = guard;

  // Burst timer and transmit code
  dtg_pkg::dtg_phase_t phase, next_phase;
  logic [31:0] bcnt, next_bcnt;
  logic [3:0]  tx_code, next_tx_code;
  logic        tx_done;
  logic [31:0] burst_lim;
  logic        tx_fin;
  assign burst_lim = prog_mode ? 32'(BURST_CYC * 2) : 32'(BURST_CYC);
  always_comb begin
    next_phase   = phase;
    next_bcnt    = bcnt;
    next_tx_code = tx_code;
    tx_fin       = 1'b0;
    case (phase)
      dtg_pkg::PH_IDLE: begin
      end
      dtg_pkg::PH_BURST: begin
        if (bcnt >= burst_lim - 1) begin
          next_phase = dtg_pkg::PH_PAUSE;
          next_bcnt  = 32'h0;
        end else begin
          next_bcnt = bcnt + 32'h1;
        end
      end
      dtg_pkg::PH_PAUSE: begin
        if (bcnt >= burst_lim - 1) begin
          next_phase = dtg_pkg::PH_IDLE;
          tx_fin     = 1'b1;
        end else begin
          next_bcnt = bcnt + 32'h1;
        end
      end
      default: begin
        next_phase = dtg_pkg::PH_IDLE;
      end
    endcase
    if (!burst_en || !tone_en) begin
      next_phase = dtg_pkg::PH_IDLE;
      tx_fin     = 1'b0;
    end
    if (wr_data) begin
      next_tx_code = i_pwdata[3:0];
      next_bcnt    = 32'h0;
      if (burst_en && tone_en) begin
        next_phase = dtg_pkg::PH_BURST;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase   <= dtg_pkg::PH_IDLE;
      bcnt    <= 32'h0;
      tx_code <= 4'h0;
    end else begin
      phase   <= next_phase;
      bcnt    <= next_bcnt;
      tx_code <= next_tx_code;
    end
  end

  logic tone_on;
  assign tone_on = tone_en &&
                   (!burst_en || phase == dtg_pkg::PH_BURST);

  // Digit code to row and column index
  function automatic logic [3:0] code_sel(input logic [3:0] c);
    case (c)
      4'h1: code_sel = 4'h0;
      4'h2: code_sel = 4'h1;
      4'h3: code_sel = 4'h2;
      4'h4: code_sel = 4'h4;
      4'h5: code_sel = 4'h5;
      4'h6: code_sel = 4'h6;
      4'h7: code_sel = 4'h8;
      4'h8: code_sel = 4'h9;
      4'h9: code_sel = 4'hA;
      4'hA: code_sel = 4'hD;
      4'hB: code_sel = 4'hC;
      4'hC: code_sel = 4'hE;
      4'hD: code_sel = 4'h3;
      4'hE: code_sel = 4'h7;
      4'hF: code_sel = 4'hB;
      default: code_sel = 4'hF;
    endcase
  endfunction

  function automatic logic [13:0] seg_len(input logic hi,
                                          input logic [1:0] i);
    case ({hi, i})
      3'h0: seg_len = 14'(`DTG_SEG_LEN(`DTG_F_ROW0));
      3'h1: seg_len = 14'(`DTG_SEG_LEN(`DTG_F_ROW1));
      3'h2: seg_len = 14'(`DTG_SEG_LEN(`DTG_F_ROW2));
      3'h3: seg_len = 14'(`DTG_SEG_LEN(`DTG_F_ROW3));
      3'h4: seg_len = 14'(`DTG_SEG_LEN(`DTG_F_COL0));
      3'h5: seg_len = 14'(`DTG_SEG_LEN(`DTG_F_COL1));
      3'h6: seg_len = 14'(`DTG_SEG_LEN(`DTG_F_COL2));
      default: seg_len = 14'(`DTG_SEG_LEN(`DTG_F_COL3));
    endcase
  endfunction

  function automatic logic [7:0] sine(input logic [4:0] idx);
    logic [7:0] m;
    m = 8'h00;
    case (idx[3:0])
      4'h0: m = 8'h00;
      4'h1: m = 8'h19;
      4'h2: m = 8'h31;
      4'h3: m = 8'h47;
      4'h4: m = 8'h5A;
      4'h5: m = 8'h6A;
      4'h6: m = 8'h76;
      4'h7: m = 8'h7D;
      4'h8: m = 8'h7F;
      4'h9: m = 8'h7D;
      4'hA: m = 8'h76;
      4'hB: m = 8'h6A;
      4'hC: m = 8'h5A;
      4'hD: m = 8'h47;
      4'hE: m = 8'h31;
      default: m = 8'h19;
    endcase
    sine = idx[4] ? `DTG_SINE_MID - m : `DTG_SINE_MID + m;
  endfunction

  // Row and column tone dividers with sine sequencers
  logic [3:0]  sel;
  logic [7:0]  samp [2];
  logic [13:0] dcnt [2];
  logic [13:0] term [2];
  assign sel = code_sel(tx_code);
  for (genvar g = 0; g < 2; g++) begin : g_tone
    logic [13:0] next_cnt;
    logic [4:0]  seg, next_seg;
    logic [7:0]  next_samp;
    assign term[g] = seg_len(g == 1, g == 0 ? sel[3:2] : sel[1:0]);
    always_comb begin
      next_cnt  = dcnt[g] + 14'h1;
      next_seg  = seg;
      next_samp = sine(seg);
      if (dcnt[g] >= term[g] - 14'h1) begin
        next_cnt = 14'h0;
        next_seg = seg + 5'h1;
      end
      if (!tone_on) begin
        next_cnt  = 14'h0;
        next_seg  = 5'h0;
        next_samp = `DTG_SINE_MID;
      end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        dcnt[g] <= 14'h0;
        seg     <= 5'h0;
        samp[g] <= `DTG_SINE_MID;
      end else begin
        dcnt[g] <= next_cnt;
        seg     <= next_seg;
        samp[g] <= next_samp;
      end
    end
  end
  assign o_row_sample = samp[0];
  assign o_col_sample = samp[1];

  // Status flags, APB registers and pin drive
  dtg_pkg::dtg_status_t st, next_st;
  logic [3:0]  next_ctrl_a, next_ctrl_b;
  logic [31:0] next_prdata;
  logic        next_slverr;
  logic        next_pin_oe;
  logic        addr_ok;
  assign addr_ok = i_paddr == `DTG_ADDR_DATA ||
                   i_paddr == `DTG_ADDR_CTRL_A ||
                   i_paddr == `DTG_ADDR_CTRL_B ||
                   i_paddr == `DTG_ADDR_STATUS;
  always_comb begin
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    if (wr_acc && i_paddr == `DTG_ADDR_CTRL_A) begin
      next_ctrl_a = i_pwdata[3:0];
    end
    if (wr_acc && i_paddr == `DTG_ADDR_CTRL_B) begin
      next_ctrl_b = i_pwdata[3:0];
    end
    next_st.dstd   = next_dstd;
    // Set wins over the read clear; only a reported flag is cleared
    next_st.rx_new = rx_set ||
                     (st.rx_new && !(rd_status &&
                      o_prdata[`DTG_ST_RXNEW]));
    next_st.tx_ready = tx_fin ||
                       (st.tx_ready && !wr_data &&
                        !(rd_status && o_prdata[`DTG_ST_TXRDY]));
    next_st.irq = irq_en && !prog_mode &&
                  (next_st.dstd || next_st.rx_new ||
                   (burst_en && next_st.tx_ready));
    next_prdata = o_prdata;
    next_slverr = 1'b0;
    if (i_psel && !i_penable) begin
      next_prdata = 32'h0;
      next_slverr = !addr_ok;
      if (!i_pwrite) begin
        case (i_paddr)
          `DTG_ADDR_DATA:   next_prdata[3:0] = rx_data;
          `DTG_ADDR_CTRL_A: next_prdata[3:0] = ctrl_a;
          `DTG_ADDR_CTRL_B: next_prdata[3:0] = ctrl_b;
          `DTG_ADDR_STATUS: next_prdata[3:0] = st;
          default:          next_prdata = 32'h0;
        endcase
      end
    end
    if (prog_mode) begin
      next_pin_oe = irq_en && !prog_wave;
    end else begin
      next_pin_oe = next_st.irq;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_a    <= `DTG_CTRL_RST;
      ctrl_b    <= `DTG_CTRL_RST;
      st        <= '0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
      o_irq_or_progress_pin_oe <= 1'b0;
    end else begin
      ctrl_a    <= next_ctrl_a;
      ctrl_b    <= next_ctrl_b;
      st        <= next_st;
      o_prdata  <= next_prdata;
      o_pslverr <= next_slverr;
      o_irq_or_progress_pin_oe <= next_pin_oe;
    end
  end
  assign o_irq_or_progress_pin_o = 1'b0;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_rx_update;
    !$stable(rx_data) |-> $rose(dstd) && $past(state) == dtg_pkg::ST_SETTLE;
  endproperty
  a_rx_update: assert property (p_rx_update)
    else $error("receive data changed without delayed steering rise");

  property p_short_burst;
    state == dtg_pkg::ST_QUAL && !early_tone_detect |=> state == dtg_pkg::ST_IDLE
      && $stable(rx_data);
  endproperty
  a_short_burst: assert property (p_short_burst)
    else $error("short burst altered receive state");

  property p_guard_follows;
    guard |-> $past(early_tone_detect) && state != dtg_pkg::ST_IDLE;
  endproperty
  a_guard_follows: assert property (p_guard_follows)
    else $error("guard driven without early detect");

  property p_dropout;
    state == dtg_pkg::ST_ABSENT && early_tone_detect && !prog_mode
      |=> state == dtg_pkg::ST_VALID && dstd;
  endproperty
  a_dropout: assert property (p_dropout)
    else $error("short dropout ended the digit");

  property p_irq_pin;
    $past(irq_en && !prog_mode) && dstd |-> o_irq_or_progress_pin_oe;
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("pin released while delayed steering active");

  property p_rxnew_clear;
    rd_status && o_prdata[`DTG_ST_RXNEW] && !rx_set |=> !st.rx_new;
  endproperty
  a_rxnew_clear: assert property (p_rxnew_clear)
    else $error("new data flag not cleared by status read");

  property p_prog_pin;
    prog_mode && irq_en && !prog_wave |=> o_irq_or_progress_pin_oe;
  endproperty
  a_prog_pin: assert property (p_prog_pin)
    else $error("progress pin not low in reject band");

  property p_prog_no_rx;
    prog_mode |=> state == dtg_pkg::ST_IDLE && !dstd;
  endproperty
  a_prog_no_rx: assert property (p_prog_no_rx)
    else $error("digit receive active in progress mode");

  property p_tone_off;
    !tone_en |=> ##1 o_row_sample == `DTG_SINE_MID
      && o_col_sample == `DTG_SINE_MID;
  endproperty
  a_tone_off: assert property (p_tone_off)
    else $error("tone output while disabled");

  property p_div_wrap;
    tone_on && dcnt[0] >= term[0] - 14'h1 && $stable(term[0])
      |=> dcnt[0] == 14'h0 || !tone_on;
  endproperty
  a_div_wrap: assert property (p_div_wrap)
    else $error("row divider did not restart at terminal count");
endmodule
`default_nettype wire

/* File: verification/dtg_det_model.sv */
// Tone detector model feeding the receive side of the core
`timescale 1ns/1ps
`default_nettype none
module dtg_det_model (
  // Clock
  input  wire logic       i_clk,
  // Detector outputs
  output logic            o_det,
  output logic [3:0]      o_dig,
  output logic            o_wave
);
  initial begin
    o_det  = 1'b0;
    o_dig  = 4'hF;
    o_wave = 1'b0;
  end
  // Tone pair present for n cycles; digit lines scrambled when released
  task automatic tone(input logic [3:0] d, input int n);
    @(posedge i_clk);
    o_dig <= d;
    o_det <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_det <= 1'b0;
    o_dig <= ~d;
  endtask
  // Hard-limited progress tone, n half periods
  task automatic wave(input int half, input int n);
    repeat (n) begin
      repeat (half) @(posedge i_clk);
      o_wave <= ~o_wave;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/dtmf_steering_and_tone_generator_bench.sv */
// Self-checking bench for the tone steering and generator core
`timescale 1ns/1ps
`default_nettype none
`include "dtg_regs.svh"
module dtmf_steering_and_tone_generator_bench;
  localparam int BST = 200;
  localparam logic [7:0] RX = `DTG_ADDR_DATA;
  localparam logic [7:0] CA = `DTG_ADDR_CTRL_A;
  localparam logic [7:0] CB = `DTG_ADDR_CTRL_B;
  localparam logic [7:0] ST = `DTG_ADDR_STATUS;
  localparam int SR = `DTG_SEG_LEN(`DTG_F_ROW0);
  localparam int SC = `DTG_SEG_LEN(`DTG_F_COL0);
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  pa;
  logic [31:0] pwd;
  logic [31:0] prd;
  logic [31:0] rd;
  logic        prdy;
  logic        perr;
  logic        er;
  logic        gt;
  logic        pin_o;
  logic        pin_oe;
  logic        pin;
  logic        det;
  logic        wav;
  logic [3:0]  dig;
  logic [7:0]  rs;
  logic [7:0]  cs;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  // Open drain with pull-up
  assign pin = pin_oe ? 1'b0 : 1'b1;
  dtg_core #(.GTP_CYC(50), .GTA_CYC(50), .BURST_CYC(BST)) i_dut (
    .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(prdy), .o_pslverr(perr), .i_early_tone_detect(det),
    .i_decoded_digit(dig), .i_progress_wave(wav),
    .o_guard_time_drive(gt), .i_irq_or_progress_pin_i(pin),
    .o_irq_or_progress_pin_o(pin_o), .o_irq_or_progress_pin_oe(pin_oe),
    .o_row_sample(rs), .o_col_sample(cs)
  );
  dtg_det_model i_det (.i_clk(clk), .o_det(det), .o_dig(dig), .o_wave(wav));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic t_reset;
    apb(0, CA, 0);
    chk("ctrl_a", 0, rd);
    apb(0, CB, 0);
    chk("ctrl_b", 0, rd);
    apb(0, ST, 0);
    chk("status", 0, rd);
    apb(0, 8'h10, 0);
    chk("unmapped", 1, er);
    chk("pin_o", 0, pin_o);
    $display("test reset done");
  endtask
  task automatic t_digit;
    apb(1, CA, 32'h4);
    fork
      i_det.tone(4'h5, 120);
      begin
        repeat (80) @(posedge clk);
        chk("guard", 1, gt);
        chk("pin_on", 1, pin_oe);
        apb(0, RX, 0);
        chk("rx", 5, rd);
      end
    join
    repeat (8) @(posedge clk);
    chk("guard_off", 0, gt);
    repeat (70) @(posedge clk);
    chk("irq_held", 1, pin_oe);
    apb(0, ST, 0);
    chk("st", 2'b01, rd[3:2]);
    apb(0, ST, 0);
    chk("rxnew", 0, rd[2]);
    chk("irq_clr", 0, pin_oe);
    i_det.tone(4'h3, 20);
    repeat (80) @(posedge clk);
    apb(0, ST, 0);
    chk("short", 0, rd[3:2]);
    i_det.tone(4'h9, 100);
    repeat (10) @(posedge clk);
    i_det.tone(4'h7, 100);
    repeat (80) @(posedge clk);
    apb(0, RX, 0);
    chk("dropout", 9, rd);
    $display("test digit done");
  endtask
  task automatic t_prog;
    apb(1, CA, 32'h6);
    fork
      i_det.wave(20, 6);
      repeat (6) begin
        repeat (12) @(posedge clk);
        chk("square", !wav, pin_oe);
        repeat (8) @(posedge clk);
      end
    join
    repeat (8) @(posedge clk);
    chk("reject", 1, pin_oe);
    i_det.tone(4'h2, 100);
    repeat (80) @(posedge clk);
    apb(0, RX, 0);
    chk("no_rx", 9, rd);
    $display("test progress done");
  endtask
  task automatic t_burst;
    int t0;
    for (int m = 0; m < 3; m++) begin
      apb(1, CB, 32'h1);
      apb(1, CA, (m == 0) ? 32'h0 : ((m == 1) ? 32'h1 : 32'h3));
      apb(1, RX, 32'h1);
      t0 = cyc;
      rd = 0;
      while (rd[1] !== 1'b1 && cyc - t0 < 1500) apb(0, ST, 0);
      if (m == 0) begin
        chk("tone_off", 0, rd[1]);
      end else begin
        chk("burst_len", 1, (cyc - t0 >= 2 * m * BST) &&
            (cyc - t0 <= 2 * m * BST + 12));
        chk("txrdy", 1, rd[1]);
      end
    end
    apb(1, CB, 0);
    apb(1, CA, 0);
    $display("test burst done");
  endtask
  task automatic t_tone;
    int tr[2];
    int tc[2];
    int nr;
    int nc;
    logic [7:0] pr;
    logic [7:0] pc;
    nr = 0;
    nc = 0;
    apb(1, CA, 32'h1);
    apb(1, RX, 32'h1);
    pr = rs;
    pc = cs;
    repeat (25000) begin
      @(posedge clk);
      if (rs !== pr && nr < 2) begin
        tr[nr] = cyc;
        nr++;
      end
      if (cs !== pc && nc < 2) begin
        tc[nc] = cyc;
        nc++;
      end
      pr = rs;
      pc = cs;
    end
    chk("row_seg", 1, nr == 2 && tr[1] - tr[0] inside {[SR-2:SR+2]});
    chk("col_seg", 1, nc == 2 && tc[1] - tc[0] inside {[SC-2:SC+2]});
    apb(1, CA, 0);
    repeat (8) @(posedge clk);
    chk("silent", 16'h8080, {rs, cs});
    $display("test tone done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    rstn = 1'b0;
    {psel, pen, pwr, pa, pwd} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_digit();
    t_prog();
    t_burst();
    t_tone();
    final_report();
  end
endmodule
`default_nettype wire
